// ==== rsw_consts.vh ====
// constants for the redundant source changeover controller
`ifndef RSW_CONSTS_VH
`define RSW_CONSTS_VH

// register byte offsets
`define RSW_OFF_CTRL 8'h00
`define RSW_OFF_STATUS 8'h04
`define RSW_OFF_SWITCH 8'h08
`define RSW_OFF_COUNT 8'h0C

// control register fields
`define RSW_CTRL_TAKEOVER 0
`define RSW_CTRL_MANUAL 1
`define RSW_CTRL_SOURCE 2
`define RSW_CTRL_RESET 3'h0

// status register fields
`define RSW_ST_SOURCE 0
`define RSW_ST_ENABLE 1
`define RSW_ST_SYNC1 2
`define RSW_ST_SYNC2 3
`define RSW_ST_MANUAL 4
`define RSW_ST_ARMED 5
`define RSW_ST_LAN 6
`define RSW_ST_REMLOCK 7
`define RSW_ST_REMOTE 8

// configuration switch positions (switch n sits at bit n-1)
`define RSW_SW_ASYNC_ALLOW 0
`define RSW_SW_OVERRIDE_LOCK 1
`define RSW_SW_REMOTE_LOCK 2
`define RSW_SW_LAN_FUNC 3
`define RSW_SW_PRIO_EN 7
`define RSW_SW_PRIO_SRC 8
`define RSW_SW_WAIT_LOCK 9

// bus answer codes
`define RSW_RESP_OKAY 2'h0
`define RSW_RESP_SLVERR 2'h2

`endif

// ==== rsw_sync2.v ====
// two-stage synchroniser for level inputs
`timescale 1ns/1ns
`default_nettype none

module rsw_sync2
#(
  parameter WIDTH = 2
)
(
  input wire core_clk,
  input wire sys_rst,
  input wire [WIDTH-1:0] asyncIn,
  output wire [WIDTH-1:0] syncOut
);

  reg [WIDTH-1:0] stage1_reg;
  reg [WIDTH-1:0] stage2_reg;

  // first stage feeds only the second
  always @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      stage1_reg <= {WIDTH{1'b0}};
      stage2_reg <= {WIDTH{1'b0}};
    end
    else
    begin
      stage1_reg <= asyncIn;
      stage2_reg <= stage1_reg;
    end
  end

  assign syncOut = stage2_reg;

endmodule
`default_nettype wire

// ==== rsw_changeover.v ====
// changeover controller with AXI4-Lite register slave
//
// Decided for this implementation: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none
`include "rsw_consts.vh"

// How it works
// [RULE1] manual mode routes outputs from the module the source selector names
// [RULE2] manual mode keeps outputs enabled regardless of synchronization
// [RULE3] automatic mode picks the source from both sync indicators
// [RULE4] master losing sync with synced backup swaps roles, no reverting
// [RULE5] both unsynchronized: no changeover, selection held
// [RULE6] source selector ignored in automatic mode
// [RULE7] async-allow off: automatic mode disables outputs while both are unsynchronized
// [RULE8] async-allow on: outputs stay driven from one module even if unsynced
// [RULE9] override lock on ignores front mode and source switches
// [RULE10] remote lock on rejects remote control requests
// [RULE11] board function switch: off chassis changeover, on network interface
// [RULE12] priority master selection only while priority enable is on
// [RULE13] priority source off picks module one, on picks module two
// [RULE14] with async allowed, wait-for-lock holds outputs off until first sync
// [RULE15] switch positions five to seven have no effect
// [RULE16] operator should keep remote control disabled for automatic changeover
// [RULE17] sync indicators pass a two-stage synchroniser before use
module rsw_changeover
#(
  parameter ADDR_W = 8,
  parameter COUNT_W = 16
)
(
  input wire core_clk,
  input wire sys_rst,
  input wire syncIn1,
  input wire syncIn2,
  input wire frontAutoMode,
  input wire frontSourceSel,
  input wire [9:0] cfgSwitch,
  output wire selSource,
  output wire outputEnable,
  output wire lanFunctionEn,
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready
);

  ////////////////////////////////////////////////////////////////////////////
  // synchronised sync indicators

  wire [1:0] syncLvl;
  wire sync1;
  wire sync2;

  // both indicators cross into the core clock
  rsw_sync2 #(.WIDTH(2)) uSync
  (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .asyncIn({syncIn2, syncIn1}), // RULE17
    .syncOut(syncLvl)
  );

  assign sync1 = syncLvl[0];
  assign sync2 = syncLvl[1];

  ////////////////////////////////////////////////////////////////////////////
  // state

  reg selSource_reg;
  reg selSource_next;
  reg outputEnable_reg;
  reg outputEnable_next;
  reg lanFunction_reg;
  reg armed_reg;
  reg armed_next;
  reg manualActive_reg;
  reg [COUNT_W-1:0] changeCount_reg;
  reg [COUNT_W-1:0] changeCount_next;
  reg [2:0] ctrl_reg;

  // configuration switch decode; positions five to seven are not looked at
  wire asyncAllow = cfgSwitch[`RSW_SW_ASYNC_ALLOW]; // RULE15
  wire frontOverrideLock = cfgSwitch[`RSW_SW_OVERRIDE_LOCK];
  wire remoteLock = cfgSwitch[`RSW_SW_REMOTE_LOCK];
  wire priorityEnable = cfgSwitch[`RSW_SW_PRIO_EN];
  wire prioritySourceSel = cfgSwitch[`RSW_SW_PRIO_SRC];
  wire waitLock = cfgSwitch[`RSW_SW_WAIT_LOCK];

  // remote control only counts while it is not locked out
  wire remoteActive = ctrl_reg[`RSW_CTRL_TAKEOVER] & ~remoteLock; // RULE10

  ////////////////////////////////////////////////////////////////////////////
  // mode and source resolution

  reg manualEff;
  reg manualSrc;

  // remote takes precedence, then front panel unless locked out
  always @*
  begin
    manualEff = 1'b0;
    manualSrc = frontSourceSel;
    if (remoteActive)
    begin
      manualEff = ctrl_reg[`RSW_CTRL_MANUAL];
      manualSrc = ctrl_reg[`RSW_CTRL_SOURCE];
    end
    else if (!frontOverrideLock) // RULE9
    begin
      manualEff = ~frontAutoMode;
      manualSrc = frontSourceSel;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // selection and output gating

  wire anySync = sync1 | sync2;
  wire curOk = selSource_reg ? sync2 : sync1;
  wire otherOk = selSource_reg ? sync1 : sync2;
  wire prioOk = prioritySourceSel ? sync2 : sync1;

  // next source, enable, first-lock flag and changeover count
  always @*
  begin
    selSource_next = selSource_reg;
    changeCount_next = changeCount_reg;
    armed_next = armed_reg | anySync;
    outputEnable_next = 1'b1;
    if (manualEff)
    begin
      selSource_next = manualSrc; // RULE1
      outputEnable_next = 1'b1; // RULE2
    end
    else
    begin
      // selector ignored here, the sync indicators and priority switches decide
      if (priorityEnable && prioOk && (selSource_reg != prioritySourceSel)) // RULE12
      begin
        selSource_next = prioritySourceSel; // RULE13
        changeCount_next = changeCount_reg + 1'b1;
      end
      else if (!curOk && otherOk) // RULE3
      begin
        selSource_next = ~selSource_reg; // RULE4
        changeCount_next = changeCount_reg + 1'b1;
      end // RULE5 RULE6
      if (!anySync)
      begin
        if (!asyncAllow)
          outputEnable_next = 1'b0; // RULE7
        else if (waitLock && !armed_next)
          outputEnable_next = 1'b0; // RULE14
        else
          outputEnable_next = 1'b1; // RULE8
      end
    end
  end

  // changeover registers
  always @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      selSource_reg <= 1'b0;
      outputEnable_reg <= 1'b0;
      armed_reg <= 1'b0;
      manualActive_reg <= 1'b0;
      lanFunction_reg <= 1'b0;
      changeCount_reg <= {COUNT_W{1'b0}};
    end
    else
    begin
      selSource_reg <= selSource_next;
      outputEnable_reg <= outputEnable_next;
      armed_reg <= armed_next;
      manualActive_reg <= manualEff;
      lanFunction_reg <= cfgSwitch[`RSW_SW_LAN_FUNC]; // RULE11
      changeCount_reg <= changeCount_next;
    end
  end

  assign selSource = selSource_reg;
  assign outputEnable = outputEnable_reg;
  assign lanFunctionEn = lanFunction_reg;

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel

  reg awReady_reg;
  reg wReady_reg;
  reg bValid_reg;
  reg [1:0] bResp_reg;
  reg awGot_reg;
  reg wGot_reg;
  reg [ADDR_W-1:0] awAddr_reg;
  reg [31:0] wData_reg;
  reg [3:0] wStrb_reg;

  wire awHs = s_axi_awvalid & awReady_reg;
  wire wHs = s_axi_wvalid & wReady_reg;
  wire awGotN = awGot_reg | awHs;
  wire wGotN = wGot_reg | wHs;
  wire [ADDR_W-1:0] wrAddr = awHs ? s_axi_awaddr : awAddr_reg;
  wire [31:0] wrData = wHs ? s_axi_wdata : wData_reg;
  wire [3:0] wrStrb = wHs ? s_axi_wstrb : wStrb_reg;
  wire bDone = bValid_reg & s_axi_bready;
  wire doWrite = awGotN & wGotN & (~bValid_reg | bDone);
  wire bValidN = doWrite | (bValid_reg & ~s_axi_bready);

  // address and data are taken in either order, answer follows both
  always @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      awReady_reg <= 1'b0;
      wReady_reg <= 1'b0;
      bValid_reg <= 1'b0;
      bResp_reg <= `RSW_RESP_OKAY;
      awGot_reg <= 1'b0;
      wGot_reg <= 1'b0;
      awAddr_reg <= {ADDR_W{1'b0}};
      wData_reg <= 32'h0;
      wStrb_reg <= 4'h0;
      ctrl_reg <= `RSW_CTRL_RESET;
    end
    else
    begin
      if (awHs)
        awAddr_reg <= s_axi_awaddr;
      if (wHs)
      begin
        wData_reg <= s_axi_wdata;
        wStrb_reg <= s_axi_wstrb;
      end
      awGot_reg <= awGotN & ~doWrite;
      wGot_reg <= wGotN & ~doWrite;
      bValid_reg <= bValidN;
      awReady_reg <= ~(awGotN & ~doWrite) & ~bValidN;
      wReady_reg <= ~(wGotN & ~doWrite) & ~bValidN;
      if (doWrite)
      begin
        bResp_reg <= `RSW_RESP_OKAY;
        if (wrAddr == `RSW_OFF_CTRL)
        begin
          if (remoteLock)
            bResp_reg <= `RSW_RESP_SLVERR; // RULE10
          else if (wrStrb[0])
            ctrl_reg <= wrData[2:0];
        end
        else if ((wrAddr != `RSW_OFF_STATUS) && (wrAddr != `RSW_OFF_SWITCH) &&
          (wrAddr != `RSW_OFF_COUNT))
          bResp_reg <= `RSW_RESP_SLVERR; // unmapped
      end
    end
  end

  assign s_axi_awready = awReady_reg;
  assign s_axi_wready = wReady_reg;
  assign s_axi_bvalid = bValid_reg;
  assign s_axi_bresp = bResp_reg;

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel

  reg arReady_reg;
  reg rValid_reg;
  reg [31:0] rData_reg;
  reg [1:0] rResp_reg;
  reg [31:0] rdWord;
  reg rdErr;

  // read mux over the register map
  always @*
  begin
    rdWord = 32'h0;
    rdErr = 1'b0;
    case (s_axi_araddr)
      `RSW_OFF_CTRL: rdWord[2:0] = ctrl_reg;
      `RSW_OFF_STATUS:
      begin
        rdWord[`RSW_ST_SOURCE] = selSource_reg;
        rdWord[`RSW_ST_ENABLE] = outputEnable_reg;
        rdWord[`RSW_ST_SYNC1] = sync1;
        rdWord[`RSW_ST_SYNC2] = sync2;
        rdWord[`RSW_ST_MANUAL] = manualActive_reg;
        rdWord[`RSW_ST_ARMED] = armed_reg;
        rdWord[`RSW_ST_LAN] = lanFunction_reg;
        rdWord[`RSW_ST_REMLOCK] = remoteLock;
        rdWord[`RSW_ST_REMOTE] = remoteActive;
      end
      `RSW_OFF_SWITCH: rdWord[9:0] = cfgSwitch;
      `RSW_OFF_COUNT: rdWord[COUNT_W-1:0] = changeCount_reg;
      default: rdErr = 1'b1;
    endcase
  end

  wire arHs = s_axi_arvalid & arReady_reg;
  wire rValidN = arHs | (rValid_reg & ~s_axi_rready);

  // one read at a time, answer the cycle after the address is taken
  always @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      arReady_reg <= 1'b0;
      rValid_reg <= 1'b0;
      rData_reg <= 32'h0;
      rResp_reg <= `RSW_RESP_OKAY;
    end
    else
    begin
      rValid_reg <= rValidN;
      arReady_reg <= ~rValidN;
      if (arHs)
      begin
        rData_reg <= rdWord;
        rResp_reg <= rdErr ? `RSW_RESP_SLVERR : `RSW_RESP_OKAY;
      end
    end
  end

  assign s_axi_arready = arReady_reg;
  assign s_axi_rvalid = rValid_reg;
  assign s_axi_rdata = rData_reg;
  assign s_axi_rresp = rResp_reg;

endmodule
`default_nettype wire

// ==== rsw_changeover_props.sv ====
// checker on the changeover selection outputs
`timescale 1ns/1ns
`default_nettype none
module rsw_changeover_props
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic syncIn1,
  input wire logic syncIn2,
  input wire logic frontAutoMode,
  input wire logic frontSourceSel,
  input wire logic [9:0] cfgSwitch,
  input wire logic selSource,
  input wire logic outputEnable,
  input wire logic lanFunctionEn
);
  // mode decode with remote control locked out
  wire aut = (frontAutoMode | cfgSwitch[1]) & cfgSwitch[2];
  wire man = !frontAutoMode & !cfgSwitch[1] & cfgSwitch[2];
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  a_lan_follows: assert property (
    !$past(sys_rst) |-> lanFunctionEn == $past(cfgSwitch[3])) else $error("lan enable wrong");
  a_manual_route: assert property (
    !$past(sys_rst) && $past(man) |-> selSource == $past(frontSourceSel) && outputEnable)
    else $error("manual selection wrong");
  a_both_off: assert property (
    (aut && !cfgSwitch[0] && !syncIn1 && !syncIn2)[*4] |-> !outputEnable)
    else $error("outputs on while both unsynced");
  a_async_on: assert property (
    (aut && cfgSwitch[0] && !cfgSwitch[9])[*4] |-> outputEnable) else $error("outputs off");
  a_hold_unsync: assert property (
    (aut && !syncIn1 && !syncIn2)[*5] |-> $stable(selSource)) else $error("changeover unsynced");
  a_lost_one: assert property (
    (aut && !syncIn1 && syncIn2)[*4] |-> selSource) else $error("no swap to module two");
  a_lost_two: assert property (
    (aut && syncIn1 && !syncIn2)[*4] |-> !selSource) else $error("no swap to module one");
  a_no_revert: assert property (
    (aut && !cfgSwitch[7] && syncIn1 && syncIn2)[*5] |-> $stable(selSource))
    else $error("selection reverted");
  a_prio_pick: assert property (
    (aut && cfgSwitch[7] && syncIn1 && syncIn2 && $stable(cfgSwitch[8]))[*4]
    |-> selSource == cfgSwitch[8]) else $error("priority master not chosen");
endmodule
bind rsw_changeover rsw_changeover_props u_props (.*);
`default_nettype wire

// ==== rsw_ref_pair.sv ====
// behavioural pair of reference input modules, sync indicators lag requests
`timescale 1ns/1ns
`default_nettype none
module rsw_ref_pair
#(
  parameter LAG = 2
)
(
  input wire logic core_clk,
  input wire logic [1:0] lockReq,
  output var logic syncOut1,
  output var logic syncOut2
);
  logic [2*LAG-1:0] shr = '0;
  // lock indicators settle LAG cycles after a request (LAG of 2 or more)
  always @(posedge core_clk)
  begin
    shr <= {shr[2*LAG-3:0], lockReq};
  end
  assign syncOut1 = shr[2*LAG-2];
  assign syncOut2 = shr[2*LAG-1];
endmodule
`default_nettype wire

// ==== tb_rsw_changeover.sv ====
// self-checking bench for the changeover controller
`timescale 1ns/1ns
`default_nettype none
module tb_rsw_changeover;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic frontAutoMode = 1'b1;
  logic frontSourceSel = 1'b1;
  logic [9:0] cfgSwitch = 10'h004;
  logic [1:0] lockReq = 2'h0;
  logic syncIn1, syncIn2, selSource, outputEnable, lanFunctionEn;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdv;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  integer mismatches = 0, n_compared = 0, cycles = 0;
  ////////////////////////////////
  rsw_changeover dut (.*);
  rsw_ref_pair refs (.core_clk(core_clk), .lockReq(lockReq), .syncOut1(syncIn1),
    .syncOut2(syncIn2));
  // 125 MHz clock
  always #4 core_clk = ~core_clk;
  ////////////////////////////////
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    begin
      n_compared++;
      if (got !== exp)
      begin
        mismatches++;
        $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  task summarize;
    begin
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  // let sync lag and pipeline settle, then compare selection outputs
  task sel(input logic s, input logic e);
    begin
      repeat (8) @(posedge core_clk);
      chk("selSource", {31'h0, s}, {31'h0, selSource});
      chk("outputEnable", {31'h0, e}, {31'h0, outputEnable});
    end
  endtask
  // bus write, address and data held until each is taken
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    begin
      @(posedge core_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
        @(posedge core_clk);
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
    end
  endtask
  // bus read, data left in rdv
  task rd(input logic [7:0] a, input logic [1:0] er);
    begin
      @(posedge core_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
        @(posedge core_clk);
        if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      rdv = s_axi_rdata;
      chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
    end
  endtask
  ////////////////////////////////
  // cycle ceiling against a hang
  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 2000)
    begin
      mismatches++;
      summarize;
    end
  end
  // main sequence
  initial
  begin
    repeat (16) @(posedge core_clk);
    sys_rst <= 1'b0;
    sel(0, 0);
    lockReq <= 2'h1;
    sel(0, 1);
    lockReq <= 2'h2;
    sel(1, 1);
    lockReq <= 2'h3;
    sel(1, 1);
    lockReq <= 2'h0;
    sel(1, 0);
    cfgSwitch <= 10'h005;
    sel(1, 1);
    frontAutoMode <= 1'b0;
    frontSourceSel <= 1'b0;
    sel(0, 1);
    frontSourceSel <= 1'b1;
    sel(1, 1);
    cfgSwitch <= 10'h007;
    frontSourceSel <= 1'b0;
    sel(1, 1);
    frontAutoMode <= 1'b1;
    cfgSwitch <= 10'h085;
    lockReq <= 2'h3;
    sel(0, 1);
    cfgSwitch <= 10'h185;
    sel(1, 1);
    cfgSwitch <= 10'h07D;
    sel(1, 1);
    chk("lanFunctionEn", 32'h1, {31'h0, lanFunctionEn});
    wr(8'h00, 32'h7, 2'h2);
    rd(8'h00, 2'h0);
    chk("ctrl", 32'h0, rdv);
    rd(8'h08, 2'h0);
    chk("switch", 32'h7D, rdv);
    // status: source 2, enabled, both synced, armed, lan, remote locked
    rd(8'h04, 2'h0);
    chk("status", 32'hEF, rdv);
    // one role swap and two priority picks so far
    rd(8'h0C, 2'h0);
    chk("count", 32'h3, rdv);
    rd(8'h10, 2'h2);
    cfgSwitch <= 10'h001;
    wr(8'h00, 32'h7, 2'h0);
    lockReq <= 2'h1;
    sel(1, 1);
    // control byte lane off: the write must leave the control bits alone
    s_axi_wstrb <= 4'hE;
    wr(8'h00, 32'h0, 2'h0);
    rd(8'h00, 2'h0);
    chk("ctrl strobe", 32'h7, rdv);
    s_axi_wstrb <= 4'hF;
    wr(8'h00, 32'h0, 2'h0);
    sel(0, 1);
    sys_rst <= 1'b1;
    cfgSwitch <= 10'h205;
    lockReq <= 2'h0;
    repeat (16) @(posedge core_clk);
    sys_rst <= 1'b0;
    sel(0, 0);
    lockReq <= 2'h2;
    sel(1, 1);
    lockReq <= 2'h0;
    sel(1, 1);
    summarize;
  end
endmodule
`default_nettype wire
